// File: src/psq_pkg.sv
// shared constants and types of the pushbutton power sequencer
// assumes a single 250 MHz clock; all intervals are whole cycles of it
package psq_pkg;

   // clock rate and interval lengths
   localparam int CLK_MHZ           = 250;     // pclk rate in MHz
   localparam int DEB_TIME_US       = 32000;   // button debounce, on and off
   localparam int INT_MIN_TIME_US   = 32000;   // least low time of event_flag_n
   localparam int BLANK_TIME_US     = 512000;  // blanking after turn-on
   localparam int LOCK_TIME_US      = 1000000; // lockout after power-up and turn-off
   localparam int KILL_TIME_US      = 30;      // least halt_power_n low pulse
   localparam int HOLD_CYCLE_US     = 1000;    // one hold_delay_cap timer cycle
   localparam int HOLD_CYCLES       = 16;      // hold timer cycles per forced turn-off

   // derived cycle counts (exact at this clock rate)
   localparam int DEB_CYC_DFLT      = DEB_TIME_US * CLK_MHZ;
   localparam int INT_MIN_CYC_DFLT  = INT_MIN_TIME_US * CLK_MHZ;
   localparam int BLANK_CYC_DFLT    = BLANK_TIME_US * CLK_MHZ;
   localparam int LOCK_CYC_DFLT     = LOCK_TIME_US * CLK_MHZ;
   localparam int KILL_CYC_DFLT     = KILL_TIME_US * CLK_MHZ;
   localparam int HOLD_CYC_DFLT     = HOLD_CYCLE_US * CLK_MHZ;

   // register byte offsets
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_INT_STAT = 8'h08;
   localparam logic [7:0] REG_INT_MASK = 8'h0C;

   // control fields
   localparam int CTRL_SMALL_BIT = 0;          // small_package variant
   localparam int CTRL_POL_BIT   = 1;          // enable output active low
   localparam logic [1:0] CTRL_RST = 2'h0;

   // status fields
   localparam int STS_ON_BIT   = 0;            // system powered
   localparam int STS_SRC_BIT  = 1;            // turn-on came from plug_detect_in
   localparam int STS_FLAG_BIT = 2;            // event flag asserted
   localparam int STS_PLUG_BIT = 3;            // plug_detect_in level
   localparam int STS_CAP_BIT  = 4;            // hold_delay_cap fitted

   // event fields, shared by status and mask
   localparam int NUM_EV        = 4;
   localparam int EV_ON_BIT     = 0;           // turn-on happened
   localparam int EV_FLAG_BIT   = 1;           // turn-off sequence began
   localparam int EV_FORCED_BIT = 2;           // forced turn-off
   localparam int EV_HALT_BIT   = 3;           // halt_power_n shutdown
   localparam logic [NUM_EV-1:0] MASK_RST = 4'h0;

   // sequencer states
   typedef enum logic [3:0] {
      ST_PWRUP, ST_OFF_WAIT, ST_ON_DEB, ST_BLANK, ST_ON_REL, ST_ON,
      ST_OFF_DEB, ST_INT_MIN, ST_HOLD, ST_OFF_REL, ST_LOCKOUT
   } psq_state_t;

endpackage

// File: src/psq_sequencer.sv
// pushbutton power sequencer with an APB register file
// assumes pins are asynchronous and an APB master on pclk
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module psq_sequencer
   import psq_pkg::*;
#(
   parameter int DEB_CYC        = DEB_CYC_DFLT,     // debounce cycles
   parameter int INT_MIN_CYC    = INT_MIN_CYC_DFLT, // least flag low cycles
   parameter int BLANK_CYC      = BLANK_CYC_DFLT,   // blanking cycles
   parameter int LOCK_CYC       = LOCK_CYC_DFLT,    // lockout cycles
   parameter int KILL_CYC       = KILL_CYC_DFLT,    // halt filter cycles
   parameter int HOLD_CYCLE_CYC = HOLD_CYC_DFLT     // one hold timer cycle
)(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // pins
   input  wire logic        button_n,
   input  wire logic        plug_detect_in,
   input  wire logic        halt_power_n,
   input  wire logic        hold_cap_fitted,
   output logic             supply_switch,
   output logic             event_flag_n,
   output logic             plug_good_out,
   output logic             irq
);

   localparam int TW = 28;   // wide enough for the one second lockout
   localparam int KW = 16;   // halt filter width

   // refuse counts the counters cannot hold
   if (LOCK_CYC >= 2**TW || BLANK_CYC >= 2**TW || DEB_CYC < 1 || INT_MIN_CYC < 1
       || HOLD_CYCLE_CYC * HOLD_CYCLES >= 2**TW || KILL_CYC >= 2**KW || KILL_CYC < 1)
   begin : g_bad_cfg
      $error("psq_sequencer: timing parameter out of range");
   end

   // synchronised pins
   logic       btn_s;        // button_n, debounced by the sequencer
   logic       plug_s;       // plug_detect_in
   logic       halt_s;       // halt_power_n
   logic       cap_s;        // hold_cap_fitted strap
   logic       btn_prev_reg; // last button level for edges
   logic       plug_prev_reg;// last plug level for edges

   psq_sync #(.W(4), .RST_VAL(4'hA)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({button_n, plug_detect_in, halt_power_n, hold_cap_fitted}),
      .q       ({btn_s, plug_s, halt_s, cap_s})
   );

   // edge memory
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         btn_prev_reg  <= 1'b1;
         plug_prev_reg <= 1'b0;
      end
      else
      begin
         btn_prev_reg  <= btn_s;
         plug_prev_reg <= plug_s;
      end
   end

   logic btn_fall;          // new press
   logic plug_rise;         // supply plugged in
   logic plug_fall;         // supply removed
   assign btn_fall  = btn_prev_reg & ~btn_s;
   assign plug_rise = plug_s & ~plug_prev_reg;
   assign plug_fall = plug_prev_reg & ~plug_s;

   // halt filter: reloads while high, so only a long low reaches zero
   logic halt_zero;
   logic halt_trip;         // filtered shutdown request
   psq_timer #(.W(KW), .RST_VAL(KW'(KILL_CYC))) u_halt_tmr (
      .pclk     (pclk),
      .presetn  (presetn),
      .load     (halt_s),
      .load_val (KW'(KILL_CYC)),
      .zero     (halt_zero)
   );
   assign halt_trip = ~halt_s & halt_zero;

   // registers written by software
   logic [1:0]        ctrl_reg;     // variant controls
   logic [NUM_EV-1:0] ev_stat_reg;  // sticky events
   logic [NUM_EV-1:0] ev_mask_reg;  // event enables
   logic small_pkg;
   logic pol_low;
   assign small_pkg = ctrl_reg[CTRL_SMALL_BIT];
   assign pol_low   = ctrl_reg[CTRL_POL_BIT];

   // sequencer state
   psq_state_t state_reg;
   psq_state_t state_next;
   logic       sys_on_reg;     // supply enabled
   logic       flag_n_reg;     // event flag pin level
   logic       src_plug_reg;   // turn-on came from plug
   logic       trig_plug_reg;  // turn-off trigger is the plug
   logic       pend_plug_reg;  // plug rose during button debounce
   logic       tmr_zero;
   logic       tmr_load;
   logic [TW-1:0] tmr_val;
   logic       go_on;          // turn on this cycle
   logic       go_on_plug;     // that turn-on is plug sourced
   logic       go_off;         // release the supply this cycle
   logic       flag_set;       // start a turn-off sequence
   logic       flag_clr;       // release the flag
   logic       trig_set_plug;  // trigger recorded with flag_set
   logic       ev_forced;      // forced turn-off event
   logic       ev_halt;        // halt shutdown event
   logic       trig_low;       // current trigger still held

   psq_timer #(.W(TW), .RST_VAL(TW'(LOCK_CYC))) u_seq_tmr (
      .pclk     (pclk),
      .presetn  (presetn),
      .load     (tmr_load),
      .load_val (tmr_val),
      .zero     (tmr_zero)
   );

   assign trig_low = trig_plug_reg ? ~plug_s : ~btn_s;

   // next state and timer reloads
   always_comb
   begin
      state_next    = state_reg;
      tmr_load      = 1'b0;
      tmr_val       = '0;
      go_on         = 1'b0;
      go_on_plug    = 1'b0;
      go_off        = 1'b0;
      flag_set      = 1'b0;
      flag_clr      = 1'b0;
      trig_set_plug = 1'b0;
      ev_forced     = 1'b0;
      ev_halt       = 1'b0;
      unique case (state_reg)
         ST_PWRUP:
            if (tmr_zero)
            begin
               if (plug_s)
               begin
                  go_on      = 1'b1;
                  go_on_plug = 1'b1;
               end
               else
                  state_next = ST_OFF_WAIT;
            end
         ST_OFF_WAIT:
            // only fresh edges start a turn-on; levels are ignored
            if (btn_fall)
            begin
               state_next = ST_ON_DEB;
               tmr_load   = 1'b1;
               tmr_val    = TW'(DEB_CYC);
            end
            else if (plug_rise)
            begin
               go_on      = 1'b1;
               go_on_plug = 1'b1;
            end
         ST_ON_DEB:
            if (btn_s)
            begin
               // a bounce hands over to a plug rise seen meanwhile
               if (pend_plug_reg || plug_rise)
               begin
                  go_on      = 1'b1;
                  go_on_plug = 1'b1;
               end
               else
                  state_next = ST_OFF_WAIT;
            end
            else if (tmr_zero)
               go_on = 1'b1;
         ST_BLANK:
            if (tmr_zero)
            begin
               if (!halt_s)
               begin
                  go_off     = 1'b1;
                  ev_halt    = 1'b1;
               end
               else if (!btn_s)
                  state_next = ST_ON_REL;
               else
                  state_next = ST_ON;
            end
         ST_ON_REL:
            // a press still held after blanking is ignored until released
            if (halt_trip)
            begin
               go_off  = 1'b1;
               ev_halt = 1'b1;
            end
            else if (btn_s)
               state_next = ST_ON;
         ST_ON:
            if (halt_trip)
            begin
               go_off  = 1'b1;
               ev_halt = 1'b1;
            end
            else if (btn_fall)
            begin
               state_next = ST_OFF_DEB;
               tmr_load   = 1'b1;
               tmr_val    = TW'(DEB_CYC);
            end
            else if (plug_fall && src_plug_reg && !small_pkg)
            begin
               flag_set      = 1'b1;
               trig_set_plug = 1'b1;
            end
         ST_OFF_DEB:
            if (halt_trip)
            begin
               go_off  = 1'b1;
               ev_halt = 1'b1;
            end
            else if (btn_s)
               state_next = ST_ON;
            else if (tmr_zero)
               flag_set = 1'b1;
         ST_INT_MIN:
            // the flag holds here whatever the trigger does
            if (halt_trip)
            begin
               go_off  = 1'b1;
               ev_halt = 1'b1;
            end
            else if (tmr_zero)
            begin
               if (!trig_low)
               begin
                  state_next = ST_ON;
                  flag_clr   = 1'b1;
               end
               else if (cap_s)
               begin
                  state_next = ST_HOLD;
                  tmr_load   = 1'b1;
                  tmr_val    = TW'(HOLD_CYCLE_CYC * HOLD_CYCLES);
               end
               else
               begin
                  go_off    = 1'b1;
                  ev_forced = 1'b1;
               end
            end
         ST_HOLD:
            if (halt_trip)
            begin
               go_off  = 1'b1;
               ev_halt = 1'b1;
            end
            else if (!trig_low)
            begin
               state_next = ST_ON;
               flag_clr   = 1'b1;
            end
            else if (tmr_zero)
            begin
               go_off    = 1'b1;
               ev_forced = 1'b1;
            end
         ST_OFF_REL:
            // lockout waits for the button to be let go
            if (btn_s)
            begin
               state_next = ST_LOCKOUT;
               tmr_load   = 1'b1;
               tmr_val    = TW'(LOCK_CYC);
            end
         ST_LOCKOUT:
            if (tmr_zero)
               state_next = ST_OFF_WAIT;
      endcase
      if (go_on)
      begin
         state_next = ST_BLANK;
         tmr_load   = 1'b1;
         tmr_val    = TW'(BLANK_CYC);
      end
      if (flag_set)
      begin
         state_next = ST_INT_MIN;
         tmr_load   = 1'b1;
         tmr_val    = TW'(INT_MIN_CYC);
      end
      if (go_off)
      begin
         state_next = ST_OFF_REL;
         flag_clr   = 1'b1;
      end
   end

   // state and plug bookkeeping
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg     <= ST_PWRUP;
         src_plug_reg  <= 1'b0;
         trig_plug_reg <= 1'b0;
         pend_plug_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (go_on)
            src_plug_reg <= go_on_plug;
         if (flag_set)
            trig_plug_reg <= trig_set_plug;
         if (state_reg == ST_OFF_WAIT || state_reg == ST_ON_DEB)
            pend_plug_reg <= plug_rise | ((state_reg == ST_ON_DEB) & pend_plug_reg);
      end
   end

   // supply enable and event flag pins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sys_on_reg <= 1'b0;
         flag_n_reg <= 1'b1;
      end
      else
      begin
         if (go_on)
            sys_on_reg <= 1'b1;
         else if (go_off)
            sys_on_reg <= 1'b0;
         if (flag_set)
            flag_n_reg <= 1'b0;
         else if (flag_clr)
            flag_n_reg <= 1'b1;
      end
   end

   assign supply_switch = sys_on_reg ^ pol_low;
   assign event_flag_n  = flag_n_reg;
   assign plug_good_out = plug_s;

   // apb access decode; zero wait states
   logic acc_wr;
   logic addr_ok;
   logic [NUM_EV-1:0] ev_now;
   logic [31:0] rd_mux;
   assign addr_ok = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
                    (paddr == REG_INT_STAT) || (paddr == REG_INT_MASK);
   assign acc_wr  = psel & penable & pwrite & addr_ok;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign ev_now  = {ev_halt, ev_forced, flag_set, go_on};

   // read data picked in the setup cycle so prdata is a flop
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         REG_CTRL:     rd_mux[1:0] = ctrl_reg;
         REG_STATUS:   rd_mux[4:0] = {cap_s, plug_s, ~flag_n_reg, src_plug_reg, sys_on_reg};
         REG_INT_STAT: rd_mux[NUM_EV-1:0] = ev_stat_reg;
         REG_INT_MASK: rd_mux[NUM_EV-1:0] = ev_mask_reg;
         default:      rd_mux = 32'h0000_0000;
      endcase
   end

   // register file; a new event wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata      <= 32'h0000_0000;
         ctrl_reg    <= CTRL_RST;
         ev_mask_reg <= MASK_RST;
         ev_stat_reg <= '0;
      end
      else
      begin
         if (psel && !penable && !pwrite)
            prdata <= rd_mux;
         if (acc_wr && paddr == REG_CTRL)
            ctrl_reg <= pwdata[1:0];
         if (acc_wr && paddr == REG_INT_MASK)
            ev_mask_reg <= pwdata[NUM_EV-1:0];
         if (acc_wr && paddr == REG_INT_STAT)
            ev_stat_reg <= (ev_stat_reg & ~pwdata[NUM_EV-1:0]) | ev_now;
         else
            ev_stat_reg <= ev_stat_reg | ev_now;
      end
   end

   assign irq = |(ev_stat_reg & ev_mask_reg);

   // helper run counters read only by the checks below
   logic [31:0] btn_low_run;
   logic [31:0] on_run;
   logic [31:0] halt_low_run;
   logic [31:0] flag_low_run;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         btn_low_run  <= '0;
         on_run       <= '0;
         halt_low_run <= '0;
         flag_low_run <= '0;
      end
      else
      begin
         btn_low_run  <= btn_s ? '0 : btn_low_run + ((&btn_low_run) ? 32'h0 : 32'h1);
         on_run       <= !sys_on_reg ? '0 : on_run + 32'h1;
         halt_low_run <= halt_s ? '0 : halt_low_run + ((&halt_low_run) ? 32'h0 : 32'h1);
         flag_low_run <= flag_n_reg ? '0 : flag_low_run + 32'h1;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_btn_src_hold;
      state_reg == ST_ON && !src_plug_reg && plug_fall && btn_s && !halt_trip
         |=> state_reg == ST_ON && event_flag_n;
   endproperty
   a_btn_src_hold: assert property (p_btn_src_hold) else $error("plug fall acted");
   property p_plug_src_off;
      state_reg == ST_ON && src_plug_reg && !small_pkg && plug_fall && btn_s && !halt_trip
         |=> state_reg == ST_INT_MIN && !event_flag_n;
   endproperty
   a_plug_src_off: assert property (p_plug_src_off) else $error("plug fall ignored");
   property p_small_pkg;
      state_reg == ST_ON && small_pkg && plug_fall && btn_s |=> state_reg != ST_INT_MIN;
   endproperty
   a_small_pkg: assert property (p_small_pkg) else $error("plug fall in small pkg");
   property p_btn_priority;
      state_reg == ST_OFF_WAIT && btn_fall |=> state_reg == ST_ON_DEB && !sys_on_reg;
   endproperty
   a_btn_priority: assert property (p_btn_priority) else $error("button lost priority");
   property p_pwrup_plug;
      state_reg == ST_PWRUP && tmr_zero && plug_s |=> sys_on_reg && src_plug_reg;
   endproperty
   a_pwrup_plug: assert property (p_pwrup_plug) else $error("no power-up turn-on");
   property p_need_edge;
      state_reg == ST_OFF_WAIT && !btn_fall && !plug_rise
         |=> !sys_on_reg && state_reg == ST_OFF_WAIT;
   endproperty
   a_need_edge: assert property (p_need_edge) else $error("turn-on without edge");
   property p_halt_off;
      halt_trip && sys_on_reg && state_reg != ST_BLANK |=> !sys_on_reg ##1 !sys_on_reg;
   endproperty
   a_halt_off: assert property (p_halt_off) else $error("halt did not release");
   property p_halt_width;
      halt_trip |-> halt_low_run >= 32'(KILL_CYC);
   endproperty
   a_halt_width: assert property (p_halt_width) else $error("halt glitch acted");
   property p_on_deb;
      $rose(sys_on_reg) && !src_plug_reg |-> btn_low_run >= 32'(DEB_CYC);
   endproperty
   a_on_deb: assert property (p_on_deb) else $error("turn-on too early");
   property p_blank;
      $fell(sys_on_reg) |-> on_run >= 32'(BLANK_CYC);
   endproperty
   a_blank: assert property (p_blank) else $error("off during blanking");
   property p_flag_min;
      $rose(flag_n_reg) && !$past(halt_trip) |-> flag_low_run >= 32'(INT_MIN_CYC);
   endproperty
   a_flag_min: assert property (p_flag_min) else $error("flag pulse too short");
   property p_hold_abort;
      state_reg == ST_HOLD && !trig_low && !halt_trip |=> state_reg == ST_ON && flag_n_reg;
   endproperty
   a_hold_abort: assert property (p_hold_abort) else $error("hold abort failed");

   c_btn_on:    cover property ($rose(sys_on_reg) && !src_plug_reg);
   c_plug_on:   cover property ($rose(sys_on_reg) && src_plug_reg);
   c_forced:    cover property (ev_forced);
   c_halt_off:  cover property (ev_halt);

endmodule

// File: src/psq_sync.sv
// two-stage synchroniser for asynchronous pins
// assumes pins idle at the reset value given
`timescale 1ns/1ps
module psq_sync
   import psq_pkg::*;
#(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
)(
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // pins and synchronised copy
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_reg;   // first stage, read only by the second

   // second stage is the only reader of the first
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_reg <= RST_VAL;
         q        <= RST_VAL;
      end
      else
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule

// File: src/psq_timer.sv
// reloadable down counter; zero flags the end of an interval
// assumes the owner reloads it on entry to each timed phase
`timescale 1ns/1ps
module psq_timer
   import psq_pkg::*;
#(
   parameter int           W       = 28,
   parameter logic [W-1:0] RST_VAL = '0
)(
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // reload and status
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   output logic              zero
);

   logic [W-1:0] cnt_reg;    // remaining cycles

   // count down to zero and stop there
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_reg <= RST_VAL;
      else if (load)
         cnt_reg <= load_val;
      else if (cnt_reg != '0)
         cnt_reg <= cnt_reg - W'(1);
   end

   assign zero = (cnt_reg == '0);

endmodule

// File: tb/psq_host_model.sv
// host model: raises halt_power_n once powered
// assumes supply_switch is active high
`timescale 1ns/1ps
module psq_host_model (
   // clock, reset and pins
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic supply_switch,
   input  wire logic kill_req,
   output logic      halt_power_n
);
   // low while unpowered or asked to shut down
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         halt_power_n <= 1'b0;
      else
         halt_power_n <= supply_switch & ~kill_req;
endmodule

// File: tb/tb.sv
// bench: pins, APB and host model around the sequencer
// assumes the shortened timing parameters below
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
   $display("FAIL %0t %h %h", $time, a, b); end end
module tb;
   import psq_pkg::*;
   localparam int T_DEB = 20, T_INT = 20, T_BLANK = 50, T_LOCK = 60, T_KILL = 5, T_HOLD = 3;
   // bus and pins
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, seed = 32'h37487D52;
   logic        button_n = 1, plug_detect_in = 0, kill = 0, err, cap = 1, pgood;
   logic        pready, pslverr, supply_switch, event_flag_n, irq, halt_power_n;
   int          num_errors = 0, tests_run = 0, n;
   always #2 pclk = ~pclk;
   psq_host_model i_host (.pclk, .presetn, .supply_switch, .kill_req(kill),
      .halt_power_n);
   psq_sequencer #(.DEB_CYC(T_DEB), .INT_MIN_CYC(T_INT), .BLANK_CYC(T_BLANK),
      .LOCK_CYC(T_LOCK), .KILL_CYC(T_KILL), .HOLD_CYCLE_CYC(T_HOLD)) i_dut (.pclk, .presetn,
      .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .button_n,
      .plug_detect_in, .halt_power_n, .hold_cap_fitted(cap), .supply_switch,
      .event_flag_n, .plug_good_out(pgood), .irq);
   task automatic end_of_test;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge pclk);
   endtask
   // one transfer; the idle edge after it keeps strobes apart
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      for (i = 0; i < 9; i++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      if (i == 9)
         num_errors++;
      if (i == 9)
         end_of_test;
      tick(1);
   endtask
   // n counts cycles until supply_switch reaches v
   task automatic wait_sw(input logic v, input int lim);
      for (n = 0; n < lim && supply_switch !== v; n++)
         @(posedge pclk);
      if (n == lim)
         num_errors++;
      if (n == lim)
         end_of_test;
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // expected enable level for an on state and polarity
   function automatic logic exp_sw(input logic on, input logic pol);
      return on ^ pol;
   endfunction
   initial
   begin
      tick(10);
      presetn <= 1;
      tick(70);
      `CHK(supply_switch, exp_sw(0, 0))
      apb(1, REG_CTRL, 32'h2);
      tick(2);
      `CHK(supply_switch, exp_sw(0, 1))
      apb(1, REG_CTRL, 32'h0);
      apb(0, 8'h10, 32'h0);
      `CHK(err, 1'b1)
      seed = lfsr(seed);
      apb(1, REG_INT_MASK, seed & 32'hF);
      apb(0, REG_INT_MASK, 32'h0);
      `CHK(rd, seed & 32'hF)
      apb(1, REG_INT_MASK, 32'h1);
      // a random press shorter than the debounce
      button_n <= 0;
      tick(1 + seed[7:4] % 15);
      button_n <= 1;
      tick(30);
      `CHK(supply_switch, 1'b0)
      button_n <= 0;
      wait_sw(1, 40);
      `CHK(n inside {[21:27]}, 1'b1)
      button_n <= 1;
      tick(60);
      `CHK(irq, 1'b1)
      // plug pulse after a button turn-on
      plug_detect_in <= 1;
      tick(5);
      plug_detect_in <= 0;
      tick(10);
      `CHK({supply_switch, event_flag_n}, 2'b11)
      apb(1, REG_INT_STAT, 32'hF);
      tick(2);
      `CHK(irq, 1'b0)
      // held press: debounce, flag minimum, 16 hold cycles
      button_n <= 0;
      wait_sw(0, 150);
      `CHK(n inside {[88:100]}, 1'b1)
      `CHK(irq, 1'b0)
      button_n <= 1;
      tick(70);
      plug_detect_in <= 1;
      wait_sw(1, 10);
      tick(60);
      plug_detect_in <= 0;
      tick(5);
      `CHK(event_flag_n, 1'b0)
      // halt glitch shorter than the filter is ignored
      kill <= 1;
      tick(T_KILL - 2);
      kill <= 0;
      tick(8);
      `CHK(supply_switch, 1'b1)
      kill <= 1;
      wait_sw(0, 40);
      `CHK(n >= T_KILL, 1'b1)
      // small_package ignores a plug fall
      kill <= 0;
      cap <= 0;
      apb(1, REG_CTRL, 32'h1);
      tick(70);
      plug_detect_in <= 1;
      wait_sw(1, 10);
      tick(60);
      plug_detect_in <= 0;
      tick(10);
      `CHK({supply_switch, event_flag_n}, 2'b11)
      // plug path without hold timer: flag minimum only
      apb(1, REG_CTRL, 32'h0);
      plug_detect_in <= 1;
      tick(5);
      plug_detect_in <= 0;
      wait_sw(0, 40);
      `CHK(n inside {[T_INT+1:T_INT+7]}, 1'b1)
      // mid-run reset with the plug already high
      plug_detect_in <= 1;
      presetn <= 0;
      tick(2);
      presetn <= 1;
      wait_sw(1, 80);
      `CHK(n >= T_LOCK, 1'b1)
      `CHK(pgood, 1'b1)
      tick(60);
      // button turn-off; the steady plug must not restart
      button_n <= 0;
      wait_sw(0, 80);
      button_n <= 1;
      tick(90);
      `CHK(supply_switch, 1'b0)
      plug_detect_in <= 0;
      tick(5);
      // press and plug rise together: button wins
      cap <= 1;
      button_n <= 0;
      plug_detect_in <= 1;
      wait_sw(1, 40);
      `CHK(n > T_DEB, 1'b1)
      button_n <= 1;
      apb(0, REG_STATUS, 32'h0);
      `CHK(rd[STS_SRC_BIT], 1'b0)
      tick(60);
      // release during the hold timer aborts the turn-off
      button_n <= 0;
      tick(50);
      `CHK(event_flag_n, 1'b0)
      button_n <= 1;
      tick(5);
      `CHK({supply_switch, event_flag_n}, 2'b11)
      end_of_test;
   end
endmodule
